// ---- hw/lpt_pkg.sv ----
// Shared constants and types for the passive LCD panel timing output.
package lpt_pkg;
	localparam int NIBBLE_W = 4;
	localparam int WORD_W = 7;
	localparam int CNT_W = 10;
	localparam int AC_CNT_W = 8;
	localparam int PULSE_W = 2;
	// Field positions inside a buffered pixel word.
	localparam int NIB_LSB = 0;
	localparam int EOL_BIT = 4;
	localparam int EOF_BIT = 5;
	localparam int ACT_BIT = 6;
	// Latch and frame pulses last two link clock cycles, shorter than one shift period.
	localparam logic [PULSE_W-1:0] PULSE_LAST = 2'h1;
	localparam int BUF_DEPTH = 2;
	// Reset values.
	localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
	localparam logic [AC_CNT_W-1:0] AC_CNT_RST = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RST = 7'h00;
	localparam logic [NIBBLE_W-1:0] NIBBLE_RST = 4'h0;

	typedef enum logic [2:0] {
		LS_IDLE,
		LS_CLK_HI,
		LS_CLK_LO,
		LS_LATCH,
		LS_FRAME
	} lpt_link_state_t;
endpackage : lpt_pkg

// ---- hw/lpt_stream_if.sv ----
// Valid/ready word carrier between the timing core and its buffer.
`timescale 1ns/1ps
interface lpt_stream_if;
	logic valid;
	logic ready;
	logic [lpt_pkg::WORD_W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : lpt_stream_if

// ---- hw/lpt_word_buf.sv ----
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ps
module lpt_word_buf (
	input wire logic clk,
	input wire logic rst_n,
	lpt_stream_if.snk in_s,
	lpt_stream_if.src out_s
);
	logic [lpt_pkg::WORD_W-1:0] mem [lpt_pkg::BUF_DEPTH];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign in_s.ready = (count != 2'h2);
	assign out_s.valid = (count != 2'h0);
	assign out_s.data = mem[rd_ptr];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	genvar gi;
	generate
		for (gi = 0; gi < lpt_pkg::BUF_DEPTH; gi++)
		begin : g_entry
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					mem[gi] <= lpt_pkg::WORD_RST;
				else if (push && (wr_ptr == 1'(gi)))
					mem[gi] <= in_s.data;
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end
endmodule : lpt_word_buf

// ---- hw/lpt_panel_timing.sv ----
// Passive LCD panel timing output: pixel stream in, panel pins out.
`timescale 1ns/1ps
module lpt_panel_timing (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lcd_clk,
	input wire logic pix_valid,
	output logic pix_ready,
	input wire logic [lpt_pkg::NIBBLE_W-1:0] pix_nibble,
	input wire logic [lpt_pkg::CNT_W-1:0] cfg_nibbles_per_line,
	input wire logic [lpt_pkg::CNT_W-1:0] cfg_lines_per_frame,
	input wire logic cfg_ac_per_frame,
	input wire logic [lpt_pkg::AC_CNT_W-1:0] cfg_ac_line_count,
	input wire logic cfg_display_on,
	output logic pixel_shift_clock,
	output logic [lpt_pkg::NIBBLE_W-1:0] lcd_pixel_nibble,
	output logic line_latch_pulse,
	output logic frame_return_pulse,
	output logic lcd_ac_polarity,
	output logic display_power_enable,
	output logic video_idle_indication
);
	// System clock side: position counters and word tagging.
	logic [lpt_pkg::CNT_W-1:0] col;
	logic [lpt_pkg::CNT_W-1:0] row;
	logic [lpt_pkg::AC_CNT_W-1:0] ac_lines;
	logic tag_eol;
	logic tag_eof;
	logic tag_act;
	logic accept;

	lpt_stream_if buf_in ();
	lpt_stream_if buf_out ();

	// Settings are sampled as nibbles are accepted and must hold while a frame streams.
	// The last nibble of a line carries the end-of-line mark.
	assign tag_eol = ({1'b0, col} + 11'h001) >= {1'b0, cfg_nibbles_per_line};
	assign tag_eof = tag_eol
		&& (({1'b0, row} + 11'h001) >= {1'b0, cfg_lines_per_frame});
	always_comb
	begin
		if (cfg_ac_per_frame)
			tag_act = tag_eof;
		else
			tag_act = tag_eol
				&& (({1'b0, ac_lines} + 9'h001) >= {1'b0, cfg_ac_line_count});
	end

	assign buf_in.valid = pix_valid;
	assign buf_in.data = {tag_act, tag_eof, tag_eol, pix_nibble};
	assign pix_ready = buf_in.ready;
	assign accept = pix_valid && buf_in.ready;

	lpt_word_buf u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_s(buf_in),
		.out_s(buf_out)
	);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			col <= lpt_pkg::CNT_RST;
			row <= lpt_pkg::CNT_RST;
		end
		else if (accept)
		begin
			if (tag_eol)
			begin
				col <= lpt_pkg::CNT_RST;
				if (tag_eof)
					row <= lpt_pkg::CNT_RST;
				else
					row <= row + 10'h001;
			end
			else
				col <= col + 10'h001;
		end
	end

	// Lines since the last AC polarity change, used in count mode.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ac_lines <= lpt_pkg::AC_CNT_RST;
		else if (accept && tag_eol)
		begin
			if (tag_act || cfg_ac_per_frame)
				ac_lines <= lpt_pkg::AC_CNT_RST;
			else
				ac_lines <= ac_lines + 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			display_power_enable <= 1'b0;
		else
			display_power_enable <= cfg_display_on;
	end

	// Word crossing: a held word and a request toggle go out, an ack toggle comes back.
	logic [lpt_pkg::WORD_W-1:0] xfer_word;
	logic req_tog;
	logic ack_s1;
	logic ack_s2;
	logic ack_tog;
	logic busy;

	// One word is in flight across the crossing at a time; the buffer absorbs the wait.
	assign busy = (req_tog != ack_s2);
	assign buf_out.ready = !busy;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			xfer_word <= lpt_pkg::WORD_RST;
			req_tog <= 1'b0;
		end
		else if (buf_out.valid && !busy)
		begin
			xfer_word <= buf_out.data;
			req_tog <= ~req_tog;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end
		else
		begin
			// The answer toggle passes two flip-flops before the system side reads it.
			ack_s1 <= ack_tog;
			ack_s2 <= ack_s1;
		end
	end

	// Link side: runs on lcd_clk, a shift clock period is at least three lcd_clk cycles.
	logic lrst_s1;
	logic lrst_s2;
	logic req_s1;
	logic req_s2;
	logic pending;
	logic [lpt_pkg::WORD_W-1:0] cur_word;
	logic [lpt_pkg::PULSE_W-1:0] pulse_cnt;
	lpt_pkg::lpt_link_state_t state;

	// The system reset reaches the link side through two flip-flops.
	// The link side therefore leaves reset two link cycles after the system side.
	always_ff @(posedge lcd_clk)
	begin
		lrst_s1 <= rst_n;
		lrst_s2 <= lrst_s1;
	end

	always_ff @(posedge lcd_clk)
	begin
		if (!lrst_s2)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
		end
		else
		begin
			req_s1 <= req_tog;
			req_s2 <= req_s1;
		end
	end

	// A word is pending while the synchronised request differs from the last answer.
	assign pending = (req_s2 != ack_tog);

	always_ff @(posedge lcd_clk)
	begin
		if (!lrst_s2)
		begin
			state <= lpt_pkg::LS_IDLE;
			ack_tog <= 1'b0;
			cur_word <= lpt_pkg::WORD_RST;
			pulse_cnt <= '0;
			pixel_shift_clock <= 1'b0;
			lcd_pixel_nibble <= lpt_pkg::NIBBLE_RST;
			line_latch_pulse <= 1'b0;
			frame_return_pulse <= 1'b0;
			video_idle_indication <= 1'b1;
		end
		else
		begin
			case (state)
				lpt_pkg::LS_IDLE:
				begin
					if (pending)
					begin
						// The held word is stable while its request is unanswered.
						cur_word <= xfer_word;
						lcd_pixel_nibble <= xfer_word[lpt_pkg::NIB_LSB +: lpt_pkg::NIBBLE_W];
						pixel_shift_clock <= 1'b1;
						ack_tog <= req_s2;
						video_idle_indication <= 1'b0;
						state <= lpt_pkg::LS_CLK_HI;
					end
					else
						video_idle_indication <= 1'b1;
				end
				lpt_pkg::LS_CLK_HI:
				begin
					// Falling edge: the panel takes the nibble here.
					pixel_shift_clock <= 1'b0;
					state <= lpt_pkg::LS_CLK_LO;
				end
				// A nibble period is at least three link cycles: high, low and this decision.
				lpt_pkg::LS_CLK_LO:
				begin
					if (cur_word[lpt_pkg::EOL_BIT])
					begin
						line_latch_pulse <= 1'b1;
						pulse_cnt <= '0;
						video_idle_indication <= 1'b1;
						state <= lpt_pkg::LS_LATCH;
					end
					else
					begin
						video_idle_indication <= !pending;
						state <= lpt_pkg::LS_IDLE;
					end
				end
				lpt_pkg::LS_LATCH:
				begin
					if (pulse_cnt == lpt_pkg::PULSE_LAST)
					begin
						line_latch_pulse <= 1'b0;
						pulse_cnt <= '0;
						if (cur_word[lpt_pkg::EOF_BIT])
						begin
							// The frame pulse starts as the last latch pulse ends, with no overlap.
							frame_return_pulse <= 1'b1;
							state <= lpt_pkg::LS_FRAME;
						end
						else
							state <= lpt_pkg::LS_IDLE;
					end
					else
						pulse_cnt <= pulse_cnt + 2'h1;
				end
				lpt_pkg::LS_FRAME:
				begin
					if (pulse_cnt == lpt_pkg::PULSE_LAST)
					begin
						frame_return_pulse <= 1'b0;
						state <= lpt_pkg::LS_IDLE;
					end
					else
						pulse_cnt <= pulse_cnt + 2'h1;
				end
				default:
				begin
					pixel_shift_clock <= 1'b0;
					line_latch_pulse <= 1'b0;
					frame_return_pulse <= 1'b0;
					video_idle_indication <= 1'b1;
					state <= lpt_pkg::LS_IDLE;
				end
			endcase
		end
	end

	// AC polarity changes as the tagged line is latched.
	// In per-frame mode only the last line of a frame carries the tag.
	always_ff @(posedge lcd_clk)
	begin
		if (!lrst_s2)
			lcd_ac_polarity <= 1'b0;
		else if (state == lpt_pkg::LS_CLK_LO && cur_word[lpt_pkg::EOL_BIT]
			&& cur_word[lpt_pkg::ACT_BIT])
			lcd_ac_polarity <= ~lcd_ac_polarity;
	end
endmodule : lpt_panel_timing

// ---- bench/lpt_panel_timing_asserts.sv ----
// Concurrent checks on the panel timing output pins.
`timescale 1ns/1ps
module lpt_panel_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lcd_clk,
	input wire logic cfg_display_on,
	input wire logic display_power_enable,
	input wire logic pixel_shift_clock,
	input wire logic [3:0] lcd_pixel_nibble,
	input wire logic line_latch_pulse,
	input wire logic frame_return_pulse,
	input wire logic lcd_ac_polarity,
	input wire logic video_idle_indication
);
	a_latch_width:
	assert property (@(posedge lcd_clk) disable iff (!rst_n) $rose(line_latch_pulse)
		|=> line_latch_pulse ##1 !line_latch_pulse) else $error("latch width");
	a_frame_width:
	assert property (@(posedge lcd_clk) disable iff (!rst_n) $rose(frame_return_pulse)
		|=> frame_return_pulse ##1 !frame_return_pulse) else $error("frame width");
	a_frame_after_latch:
	assert property (@(posedge lcd_clk) disable iff (!rst_n) $rose(frame_return_pulse)
		|-> $fell(line_latch_pulse)) else $error("frame not after latch");
	a_clock_idle_latch:
	assert property (@(posedge lcd_clk) disable iff (!rst_n)
		line_latch_pulse |-> !pixel_shift_clock) else $error("shift during latch");
	a_shift_period:
	assert property (@(posedge lcd_clk) disable iff (!rst_n)
		pixel_shift_clock |=> !pixel_shift_clock [*2]) else $error("shift period");
	a_data_on_rise:
	assert property (@(posedge lcd_clk) disable iff (!rst_n) $changed(lcd_pixel_nibble)
		|-> $rose(pixel_shift_clock)) else $error("data off rising edge");
	a_polarity_on_latch:
	assert property (@(posedge lcd_clk) disable iff (!rst_n) $changed(lcd_ac_polarity)
		|-> $rose(line_latch_pulse)) else $error("polarity off latch");
	a_idle_when_shift:
	assert property (@(posedge lcd_clk) disable iff (!rst_n)
		pixel_shift_clock |-> !video_idle_indication) else $error("idle while shifting");
	a_enable_follows:
	assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> display_power_enable == $past(cfg_display_on)) else $error("enable");
endmodule : lpt_panel_checker
bind lpt_panel_timing lpt_panel_checker lpt_panel_checker_i (.*);

// ---- bench/lpt_panel_model.sv ----
// Passive panel that samples nibbles and counts lines, frames and polarity flips.
`timescale 1ns/1ps
module lpt_panel_model (
	input wire logic shift_clk,
	input wire logic [3:0] nibble,
	input wire logic latch,
	input wire logic frame,
	input wire logic pol,
	input wire logic idle
);
	logic [3:0] seen[$];
	int lens[$];
	int fill = 0;
	int lines = 0;
	int frames = 0;
	int flips = 0;
	int run = 0;
	int gap = 0;
	int reads = 0;
	int clash = 0;
	always @(negedge shift_clk)
	begin
		seen.push_back(nibble);
		fill++;
		// A shift edge inside a quiet period would disturb a touchscreen reading.
		if (idle === 1'b1)
			clash++;
	end
	// A touchscreen reading is started each time the video goes quiet.
	always @(posedge idle)
		reads++;
	always @(posedge latch)
	begin
		lens.push_back(fill);
		fill = 0;
		lines++;
		run++;
	end
	always @(posedge frame)
	begin
		frames++;
		fill = 0;
	end
	// The delay lets the latch counted on the same edge land first.
	always @(pol)
	begin
		#1;
		flips++;
		gap = run;
		run = 0;
	end
endmodule : lpt_panel_model

// ---- bench/lpt_panel_timing_tb.sv ----
// Self-checking bench for the panel timing output.
`timescale 1ns/1ps
module lpt_panel_timing_tb;
	logic clk = 0, lcd_clk = 0, rst_n = 0, pix_valid = 0, cfg_ac_per_frame = 1;
	logic cfg_display_on = 0, pix_ready, shift, latch, frame, pol, en, idle;
	logic [3:0] pix_nibble = 4'h0, nib;
	logic [7:0] cfg_ac_line_count = 8'h01;
	int n_mismatch = 0, comparisons = 0, cyc = 0, stalls = 0;
	lpt_panel_timing lpt_panel_timing_i (.clk(clk), .rst_n(rst_n), .lcd_clk(lcd_clk),
		.pix_valid(pix_valid), .pix_ready(pix_ready), .pix_nibble(pix_nibble),
		.cfg_nibbles_per_line(10'h003), .cfg_lines_per_frame(10'h002),
		.cfg_ac_per_frame(cfg_ac_per_frame), .cfg_ac_line_count(cfg_ac_line_count),
		.cfg_display_on(cfg_display_on), .pixel_shift_clock(shift), .lcd_pixel_nibble(nib),
		.line_latch_pulse(latch), .frame_return_pulse(frame), .lcd_ac_polarity(pol),
		.display_power_enable(en), .video_idle_indication(idle));
	lpt_panel_model p (.shift_clk(shift), .nibble(nib), .latch(latch), .frame(frame),
		.pol(pol), .idle(idle));
	initial forever #20 clk = ~clk;
	initial
	begin
		#7;
		forever #80 lcd_clk = ~lcd_clk;
	end
	task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	// Offers words faster than the panel drains them, so the buffer refuses some.
	task scenario(input logic per, input int acn, input int nf);
		// Start on a rising edge so that the first word is offered exactly once.
		@(posedge clk);
		p.seen.delete();
		p.lens.delete();
		p.lines = 0;
		p.frames = 0;
		p.flips = 0;
		p.run = 0;
		p.gap = 0;
		p.fill = 0;
		p.reads = 0;
		p.clash = 0;
		stalls = 0;
		cfg_ac_per_frame <= per;
		cfg_ac_line_count <= acn[7:0];
		for (int i = 0; i < 6 * nf; i++)
		begin
			pix_nibble <= i[3:0];
			pix_valid <= 1'b1;
			@(negedge clk);
			while (pix_ready !== 1'b1)
			begin
				stalls++;
				@(negedge clk);
			end
			@(posedge clk);
		end
		pix_valid <= 1'b0;
		wait (p.frames == nf);
		@(negedge frame);
		@(negedge clk);
		check("idle", idle, 1);
		check("ready", pix_ready, 1);
		check("stalled", stalls > 0, 1);
		check("nibbles", p.seen.size(), 6 * nf);
		foreach (p.seen[i]) check("data", p.seen[i], i % 16);
		foreach (p.lens[i]) check("line length", p.lens[i], 3);
		check("lines", p.lines, 2 * nf);
		check("flips", p.flips, per ? nf : 2 * nf / acn);
		check("gap", p.gap, per ? 2 : acn);
		check("quiet periods", p.reads >= 2 * nf, 1);
		check("shift while idle", p.clash, 0);
	endtask : scenario
	task enable_check;
		for (int v = 1; v >= 0; v--)
		begin
			@(posedge clk);
			cfg_display_on <= v[0];
			@(posedge clk);
			@(negedge clk);
			check("enable", en, v[0]);
		end
	endtask : enable_check
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	initial
	begin
		repeat (10) @(posedge lcd_clk);
		@(posedge clk);
		rst_n <= 1'b1;
		enable_check();
		scenario(1'b1, 1, 2);
		scenario(1'b0, 3, 3);
		summarize();
	end
endmodule : lpt_panel_timing_tb
